// *** verilog/pll_lock_clock_selector.sv ***
// PLL lock-loss clock selector with gear divider and Wishbone registers
//
// Operation
// - Output clock from the PLL stays gated off after reset until lock.
// - Lock lost with loss reset disabled: clock keeps running, no reset.
// - Lock timer runs from the input clock, unaffected by lock.
// - Software sets switch-to-backup only while limp enable already set.
// - Lock loss with hard reset disables PLL output until lock returns.
// - During hard reset switch-to-backup follows the inverse of lock.
// - Switch-to-backup plus limp enable runs the clock from backup.
// - Every lock status change raises a maskable interrupt event.
// - Divider takes PLL output normally, backup clock in limp mode.
// - Divider always divides the source by at least two.
// - Gear changes scale the clock while PLL lock is kept.
// - New gear setting is taken up at the next half-period end, at any time.
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module pll_lock_clock_selector (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic PLL_LOCK,
    input wire logic BACKUP_CLOCK,
    input wire logic HARD_RESET_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic SYS_CLK,
    output logic LIMP_ACTIVE,
    output logic HARD_RESET_REQ,
    output logic IRQ
);
    localparam int GW = pllsel_pkg::GEAR_W;
    localparam int IN = pllsel_pkg::IRQ_N;

    typedef struct packed {
        logic loss_lock_reset_en;
        logic limp_enable;
        logic switch_to_backup;
        logic [GW-1:0] gear;
        logic [IN-1:0] irq_stat;
        logic [IN-1:0] irq_mask;
        logic [31:0] timer;
        logic lock_prev;
        logic pll_gate;
        logic limp_sel;
        logic bk_prev;
        logic hard_reset_n_req;
        logic ack;
        logic [31:0] dat;
        logic irq;
        logic sysclk;
    } top_t;
    top_t r;
    top_t n;

    logic lock_s;
    logic bk_s;
    logic hard_reset_n_s;
    logic hr_act;
    logic dclk;
    logic req;
    logic wr;
    logic tick;
    logic run;
    logic [GW:0] half;
    logic [IN-1:0] ev;
    logic [31:0] rd;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    pin_sync3 #(.RST_VAL(pllsel_pkg::LOCK_IDLE)) u_lock_sync (
        .clk(MCLK),
        .rst(SYS_RST),
        .d(PLL_LOCK),
        .q(lock_s)
    );

    pin_sync3 #(.RST_VAL(pllsel_pkg::BACKUP_IDLE)) u_bk_sync (
        .clk(MCLK),
        .rst(SYS_RST),
        .d(BACKUP_CLOCK),
        .q(bk_s)
    );

    pin_sync3 #(.RST_VAL(pllsel_pkg::HARD_RESET_N_IDLE)) u_hr_sync (
        .clk(MCLK),
        .rst(SYS_RST),
        .d(HARD_RESET_N),
        .q(hard_reset_n_s)
    );

    assign hr_act = ~hard_reset_n_s;

    ////////////////////////////////////////////////////////////////////
    // Divider source and gear
    // Normal: one tick per VCO cycle; limp: one per backup rising edge
    assign tick = r.limp_sel ? (bk_s & ~r.bk_prev) : 1'b1;
    // Limp always runs; PLL path only while ungated
    assign run = r.limp_sel | r.pll_gate;
    // Half period of gear+1 ticks: ratio never below two
    assign half = {1'b0, r.gear} + {{GW{1'b0}}, 1'b1};

    clk_gear_div #(.HALF_W(GW + 1)) u_div (
        .clk(MCLK),
        .rst(SYS_RST),
        .tick(tick),
        .run(run),
        .half(half),
        .div_clk(dclk)
    );

    ////////////////////////////////////////////////////////////////////
    // Bus decode and read mux
    assign req = WB_CYC_I & WB_STB_I;
    assign wr = req & WB_WE_I & r.ack;
    assign ev[pllsel_pkg::IRQ_LOCK_GAIN_BIT] = lock_s & ~r.lock_prev;
    assign ev[pllsel_pkg::IRQ_LOCK_LOSS_BIT] = ~lock_s & r.lock_prev;

    // Register read data; unmapped offsets read zero
    always_comb begin
        rd = pllsel_pkg::READ_ZERO;
        case (WB_ADR_I)
            pllsel_pkg::PWR_RST_CTRL_OFS: begin
                rd[pllsel_pkg::LOSS_LOCK_RESET_EN_BIT] = r.loss_lock_reset_en;
            end
            pllsel_pkg::SYS_CLK_CTRL_OFS: begin
                rd[pllsel_pkg::LIMP_ENABLE_BIT] = r.limp_enable;
                rd[pllsel_pkg::SWITCH_TO_BACKUP_BIT] = r.switch_to_backup;
                rd[pllsel_pkg::GEAR_LSB +: GW] = r.gear;
            end
            pllsel_pkg::CLK_STATUS_OFS: begin
                rd[pllsel_pkg::LOCKED_BIT] = lock_s;
                rd[pllsel_pkg::LIMP_ACTIVE_BIT] = r.limp_sel;
                rd[pllsel_pkg::PLL_CLK_EN_BIT] = r.pll_gate;
                rd[pllsel_pkg::HARD_RESET_BIT] = hr_act;
            end
            pllsel_pkg::IRQ_STATUS_OFS: begin
                rd[IN-1:0] = r.irq_stat;
            end
            pllsel_pkg::IRQ_MASK_OFS: begin
                rd[IN-1:0] = r.irq_mask;
            end
            pllsel_pkg::LOCK_TIMER_OFS: begin
                rd = r.timer;
            end
            default: begin
                rd = pllsel_pkg::READ_ZERO;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        n = r;
        // One-cycle acknowledge, read data captured with it
        n.ack = req & ~r.ack;
        if (req & ~r.ack) begin
            n.dat = rd;
        end
        // Control register writes
        if (wr && WB_SEL_I[0]) begin
            case (WB_ADR_I)
                pllsel_pkg::PWR_RST_CTRL_OFS: begin
                    n.loss_lock_reset_en =
                        WB_DAT_I[pllsel_pkg::LOSS_LOCK_RESET_EN_BIT];
                end
                pllsel_pkg::SYS_CLK_CTRL_OFS: begin
                    n.limp_enable = WB_DAT_I[pllsel_pkg::LIMP_ENABLE_BIT];
                    n.gear = WB_DAT_I[pllsel_pkg::GEAR_LSB +: GW];
                    // Set only if limp already enabled; clear always
                    if (!WB_DAT_I[pllsel_pkg::SWITCH_TO_BACKUP_BIT]) begin
                        n.switch_to_backup = 1'b0;
                    end else if (r.limp_enable) begin
                        n.switch_to_backup = 1'b1;
                    end
                end
                pllsel_pkg::IRQ_MASK_OFS: begin
                    n.irq_mask = WB_DAT_I[IN-1:0];
                end
                default: begin
                end
            endcase
        end
        // Hard reset forces switch-to-backup to the inverse of lock
        if (hr_act) begin
            n.switch_to_backup = ~lock_s;
        end
        // Sticky change flags: write one clears, new event wins
        if (wr && WB_SEL_I[0] && WB_ADR_I == pllsel_pkg::IRQ_STATUS_OFS) begin
            n.irq_stat = r.irq_stat & ~WB_DAT_I[IN-1:0];
        end
        n.irq_stat = n.irq_stat | ev;
        n.lock_prev = lock_s;
        // Timer on the input clock, cleared by any write
        if (wr && WB_ADR_I == pllsel_pkg::LOCK_TIMER_OFS) begin
            n.timer = pllsel_pkg::TIMER_RST;
        end else begin
            n.timer = r.timer + 32'h0000_0001;
        end
        // PLL path gate: opens on lock, closes under hard reset or our own request
        if (lock_s) begin
            n.pll_gate = 1'b1;
        end else if (hr_act || r.hard_reset_n_req) begin
            n.pll_gate = 1'b0;
        end
        // Lock loss with reset enabled requests hard reset until relock
        if (lock_s) begin
            n.hard_reset_n_req = 1'b0;
        end else if (ev[pllsel_pkg::IRQ_LOCK_LOSS_BIT]) begin
            n.hard_reset_n_req = r.loss_lock_reset_en;
        end
        // Source change only while divided clock is low
        if (!dclk) begin
            n.limp_sel = r.switch_to_backup & r.limp_enable;
        end
        n.bk_prev = bk_s;
        n.irq = |(n.irq_stat & n.irq_mask);
        n.sysclk = dclk;
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            r <= '0;
            r.gear <= pllsel_pkg::GEAR_RST;
            r.irq_mask <= pllsel_pkg::IRQ_MASK_RST;
            r.timer <= pllsel_pkg::TIMER_RST;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from flops
    assign WB_DAT_O = r.dat;
    assign WB_ACK_O = r.ack;
    assign SYS_CLK = r.sysclk;
    assign LIMP_ACTIVE = r.limp_sel;
    assign HARD_RESET_REQ = r.hard_reset_n_req;
    assign IRQ = r.irq;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);

    // Bus handshake steps
    sequence bus_req_s;
        req && !r.ack;
    endsequence
    sequence bus_ack_s;
        r.ack ##1 !r.ack;
    endsequence

    wb_ack_one_a: assert property (bus_req_s |=> bus_ack_s)
        else $error("ack not one cycle after request");

    gate_until_lock_a: assert property ($rose(r.pll_gate) |-> $past(lock_s))
        else $error("PLL path opened without lock");

    keep_running_a: assert property (
        (r.pll_gate && !lock_s && !hr_act && !r.hard_reset_n_req) |=> r.pll_gate)
        else $error("clock stopped on lock loss without reset");

    no_reset_req_a: assert property (
        (ev[pllsel_pkg::IRQ_LOCK_LOSS_BIT] && !r.loss_lock_reset_en)
        |=> !HARD_RESET_REQ)
        else $error("reset requested with loss reset disabled");

    timer_runs_a: assert property (
        !(wr && WB_ADR_I == pllsel_pkg::LOCK_TIMER_OFS)
        |=> r.timer == $past(r.timer) + 32'h0000_0001)
        else $error("lock timer did not advance");

    backup_guard_a: assert property (
        $rose(r.switch_to_backup) |-> $past(r.limp_enable) || $past(hr_act))
        else $error("backup switch set without limp enable");

    hr_gate_off_a: assert property ((hr_act && !lock_s) |=> !r.pll_gate)
        else $error("PLL path open during hard reset without lock");

    hr_reset_req_a: assert property (
        (ev[pllsel_pkg::IRQ_LOCK_LOSS_BIT] && r.loss_lock_reset_en)
        |=> HARD_RESET_REQ)
        else $error("no reset request on lock loss");

    hr_backup_a: assert property (
        hr_act |=> r.switch_to_backup == !$past(lock_s))
        else $error("backup bit not following lock in hard reset");

    limp_enter_a: assert property (
        (r.switch_to_backup && r.limp_enable && !dclk) |=> r.limp_sel)
        else $error("limp mode not entered");

    lock_event_a: assert property (
        $changed(lock_s) |=> (r.irq_stat & $past(ev)) == $past(ev))
        else $error("lock change not flagged");

    limp_source_a: assert property (
        (r.limp_sel && !(bk_s && !r.bk_prev)) |-> !tick)
        else $error("limp divider ticked without backup edge");

    switch_low_a: assert property ($changed(r.limp_sel) |-> !$past(dclk))
        else $error("source switched while clock high");

    irq_level_a: assert property (
        |(r.irq_stat & r.irq_mask) |-> IRQ)
        else $error("interrupt not raised for unmasked flag");

    irq_quiet_a: assert property (
        !(|(r.irq_stat & r.irq_mask)) |-> !IRQ)
        else $error("interrupt raised with no unmasked flag");

    // Own reset request closes the PLL path until relock
    hr_req_gate_a: assert property (
        (r.hard_reset_n_req && !lock_s) |=> !r.pll_gate)
        else $error("PLL path open while reset requested");

    relock_clear_a: assert property (lock_s |=> !r.hard_reset_n_req)
        else $error("reset request kept after relock");

    // Flags only fall through a write-one-clear
    irq_sticky_a: assert property (
        !(wr && WB_SEL_I[0] && WB_ADR_I == pllsel_pkg::IRQ_STATUS_OFS)
        |=> (r.irq_stat & $past(r.irq_stat)) == $past(r.irq_stat))
        else $error("interrupt flag lost without clear");

    timer_clear_a: assert property (
        (wr && WB_ADR_I == pllsel_pkg::LOCK_TIMER_OFS)
        |=> r.timer == pllsel_pkg::TIMER_RST)
        else $error("lock timer not cleared by write");

    // No acknowledge without a request
    no_ack_idle_a: assert property (!req |=> !r.ack)
        else $error("ack without request");
endmodule : pll_lock_clock_selector

// *** verilog/pllsel_pkg.sv ***
// Register map, field positions and reset values of the PLL clock selector
package pllsel_pkg;
    // Register byte offsets
    localparam logic [7:0] PWR_RST_CTRL_OFS = 8'h00;
    localparam logic [7:0] SYS_CLK_CTRL_OFS = 8'h04;
    localparam logic [7:0] CLK_STATUS_OFS = 8'h08;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h0C;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
    localparam logic [7:0] LOCK_TIMER_OFS = 8'h14;
    // Control field positions
    localparam int LOSS_LOCK_RESET_EN_BIT = 0;
    localparam int LIMP_ENABLE_BIT = 0;
    localparam int SWITCH_TO_BACKUP_BIT = 1;
    localparam int GEAR_LSB = 4;
    localparam int GEAR_W = 3;
    // Status field positions
    localparam int LOCKED_BIT = 0;
    localparam int LIMP_ACTIVE_BIT = 1;
    localparam int PLL_CLK_EN_BIT = 2;
    localparam int HARD_RESET_BIT = 3;
    // Interrupt event positions
    localparam int IRQ_N = 2;
    localparam int IRQ_LOCK_GAIN_BIT = 0;
    localparam int IRQ_LOCK_LOSS_BIT = 1;
    // Reset values
    localparam logic [GEAR_W-1:0] GEAR_RST = 3'h0;
    localparam logic [IRQ_N-1:0] IRQ_MASK_RST = 2'h0;
    localparam logic [31:0] TIMER_RST = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
    // Synchroniser depth and idle levels
    localparam int SYNC_STAGES = 3;
    localparam logic LOCK_IDLE = 1'b0;
    localparam logic HARD_RESET_N_IDLE = 1'b1;
    localparam logic BACKUP_IDLE = 1'b0;
endpackage : pllsel_pkg

// *** verilog/pin_sync3.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } sync_t;
    sync_t r;
    sync_t n;

    // Stage chain; output follows once stages two and three agree
    always_comb begin
        n = r;
        n.s1 = d;
        n.s2 = r.s1;
        n.s3 = r.s2;
        if (r.s2 == r.s3) begin
            n.q = r.s2;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
        end else begin
            r <= n;
        end
    end

    assign q = r.q;

    // Output only moves on an agreed level
    sync_agree_a: assert property (@(posedge clk) disable iff (rst)
        $changed(r.q) |-> $past(r.s2) == $past(r.s3))
        else $error("sync output changed without agreement");
endmodule : pin_sync3

// *** verilog/clk_gear_div.sv ***
// Glitch-free gear divider producing the system clock from source ticks
`timescale 1ns/1ps
module clk_gear_div #(
    parameter int HALF_W = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic run,
    input wire logic [HALF_W-1:0] half,
    output logic div_clk
);
    typedef struct packed {
        logic [HALF_W-1:0] cnt;
        logic clk;
    } div_t;
    div_t r;
    div_t n;

    // Elaboration check; a half period counter needs two bits
    if (HALF_W < 2) begin : g_half_w_check
        $error("clk_gear_div: HALF_W must be at least 2");
    end

    // Toggle at half-period end; rise only while running, fall always
    always_comb begin
        n = r;
        if (tick) begin
            if (r.cnt != '0) begin
                n.cnt = r.cnt - 1'b1;
            end else if (r.clk || run) begin
                n.clk = ~r.clk;
                n.cnt = half - 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign div_clk = r.clk;

    // Edges only on a source tick, rising only when enabled
    div_tick_a: assert property (@(posedge clk) disable iff (rst)
        $changed(r.clk) |-> $past(tick))
        else $error("divider edge without source tick");
    div_rise_a: assert property (@(posedge clk) disable iff (rst)
        $rose(r.clk) |-> $past(run))
        else $error("divider rose while stopped");
endmodule : clk_gear_div

// *** verif/pll_lock_clock_selector_tb.sv ***
// Self-checking bench for the PLL lock-loss clock selector
`timescale 1ns/1ps
module pll_lock_clock_selector_tb;
    logic MCLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic PLL_LOCK = 1'b0;
    logic BACKUP_CLOCK = 1'b0;
    logic HARD_RESET_N = 1'b1;
    logic WB_CYC_I = 1'b0;
    logic WB_STB_I = 1'b0;
    logic WB_WE_I = 1'b0;
    logic [7:0] WB_ADR_I = 8'h00;
    logic [3:0] WB_SEL_I = 4'h0;
    logic [31:0] WB_DAT_I = 32'h0000_0000;
    logic [31:0] WB_DAT_O;
    logic WB_ACK_O;
    logic SYS_CLK;
    logic LIMP_ACTIVE;
    logic HARD_RESET_REQ;
    logic IRQ;
    int err_total = 0;
    int samples_checked = 0;
    int cyc_n = 0;
    int take_n;
    int n;
    int t1;
    logic [63:0] exp_q[$];
    logic [63:0] mon_e;
    logic [31:0] rng = 32'h0001_2ED1;
    logic [31:0] rd_v;
    logic [2:0] g;

    pll_lock_clock_selector dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .PLL_LOCK(PLL_LOCK),
        .BACKUP_CLOCK(BACKUP_CLOCK), .HARD_RESET_N(HARD_RESET_N), .WB_CYC_I(WB_CYC_I),
        .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
        .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SYS_CLK(SYS_CLK),
        .LIMP_ACTIVE(LIMP_ACTIVE), .HARD_RESET_REQ(HARD_RESET_REQ), .IRQ(IRQ));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, cycle count and backup clock of eight cycles
    always #2.5 MCLK = ~MCLK;

    always @(posedge MCLK) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n % 4 == 0) begin
            BACKUP_CLOCK <= ~BACKUP_CLOCK;
        end
    end

    // Read data against the oldest note
    always @(posedge MCLK) begin
        if (WB_ACK_O === 1'b1 && WB_WE_I === 1'b0 && exp_q.size() > 0) begin
            mon_e = exp_q.pop_front();
            chk("read data", mon_e[31:0], WB_DAT_O & mon_e[63:32]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs

    // One classic cycle, held until ack, then one idle cycle
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_ADR_I <= a;
        WB_SEL_I <= 4'hF;
        WB_DAT_I <= d;
        k = 0;
        do begin
            @(posedge MCLK);
            k++;
        end while (WB_ACK_O !== 1'b1);
        chk("ack latency", 32'h0000_0002, k);
        take_n = cyc_n - k;
        rd_v = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        WB_WE_I <= 1'b0;
        @(posedge MCLK);
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        exp_q.push_back({m, e & m});
        wb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic cyc(input int c);
        repeat (c) @(posedge MCLK);
    endtask : cyc

    // Length of one high phase of the system clock, in clock cycles
    task automatic hi_len(output int h);
        int k;
        k = 0;
        while (SYS_CLK !== 1'b0 && k < 200) begin
            @(posedge MCLK);
            k++;
        end
        while (SYS_CLK !== 1'b1 && k < 200) begin
            @(posedge MCLK);
            k++;
        end
        h = 0;
        while (SYS_CLK === 1'b1 && h < 200) begin
            @(posedge MCLK);
            h++;
        end
    endtask : hi_len

    task automatic wrap_up;
        $display("Comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge MCLK);
        err_total++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        cyc(6);
        SYS_RST <= 1'b0;
        cyc(1);
        rd(pllsel_pkg::CLK_STATUS_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
        rd(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
        rd(pllsel_pkg::IRQ_MASK_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
        for (int i = 0; i < 30; i++) begin
            @(posedge MCLK);
            chk("gated clock", 32'h0000_0000, {31'h0, SYS_CLK});
        end
        // First lock opens the gate and flags a change
        PLL_LOCK <= 1'b1;
        cyc(10);
        rd(pllsel_pkg::CLK_STATUS_OFS, 32'h0000_0005, 32'h0000_0005);
        rd(pllsel_pkg::IRQ_STATUS_OFS, 32'h0000_0003, 32'h0000_0001);
        chk("masked irq", 32'h0000_0000, {31'h0, IRQ});
        wb(1'b1, pllsel_pkg::IRQ_MASK_OFS, 32'h0000_0003);
        cyc(2);
        chk("unmasked irq", 32'h0000_0001, {31'h0, IRQ});
        wb(1'b1, pllsel_pkg::IRQ_STATUS_OFS, 32'h0000_0001);
        cyc(2);
        chk("cleared irq", 32'h0000_0000, {31'h0, IRQ});
        // Random gears, each applied without waiting for a pause
        for (int i = 0; i < 4; i++) begin
            rng = xs(rng);
            g = rng[2:0];
            wb(1'b1, pllsel_pkg::SYS_CLK_CTRL_OFS, {25'h0, g, 4'h0});
            // First phase may have been loaded with the old gear
            hi_len(n);
            hi_len(n);
            chk("gear half period", {29'h0, g} + 32'h0000_0001, n);
        end
        wb(1'b1, pllsel_pkg::SYS_CLK_CTRL_OFS, 32'h0000_0000);
        // Lock loss with loss reset disabled keeps the clock running
        PLL_LOCK <= 1'b0;
        cyc(10);
        chk("no hard reset", 32'h0000_0000, {31'h0, HARD_RESET_REQ});
        hi_len(n);
        chk("running half period", 32'h0000_0001, n);
        rd(pllsel_pkg::IRQ_STATUS_OFS, 32'h0000_0002, 32'h0000_0002);
        chk("loss irq", 32'h0000_0001, {31'h0, IRQ});
        wb(1'b1, pllsel_pkg::IRQ_STATUS_OFS, 32'h0000_0003);
        // Timer keeps counting input clocks while unlocked
        wb(1'b0, pllsel_pkg::LOCK_TIMER_OFS, 32'h0000_0000);
        t1 = take_n - int'(rd_v);
        cyc(17);
        wb(1'b0, pllsel_pkg::LOCK_TIMER_OFS, 32'h0000_0000);
        chk("lock timer", take_n - t1, rd_v);
        // Any write clears the timer; next read one cycle later
        wb(1'b1, pllsel_pkg::LOCK_TIMER_OFS, 32'h0000_0000);
        rd(pllsel_pkg::LOCK_TIMER_OFS, 32'hFFFF_FFFF, 32'h0000_0001);
        // Backup switch refused without limp enable, then taken
        wb(1'b1, pllsel_pkg::SYS_CLK_CTRL_OFS, 32'h0000_0002);
        rd(pllsel_pkg::SYS_CLK_CTRL_OFS, 32'h0000_0003, 32'h0000_0000);
        wb(1'b1, pllsel_pkg::SYS_CLK_CTRL_OFS, 32'h0000_0001);
        wb(1'b1, pllsel_pkg::SYS_CLK_CTRL_OFS, 32'h0000_0003);
        rd(pllsel_pkg::SYS_CLK_CTRL_OFS, 32'h0000_0003, 32'h0000_0003);
        n = 0;
        while (LIMP_ACTIVE !== 1'b1 && n < 300) begin
            @(posedge MCLK);
            n++;
        end
        chk("limp entered", 32'h0000_0001, {31'h0, LIMP_ACTIVE});
        // First high phase was started by the PLL path
        hi_len(n);
        hi_len(n);
        chk("limp half period", 32'h0000_0008, n);
        wb(1'b1, pllsel_pkg::SYS_CLK_CTRL_OFS, 32'h0000_0001);
        n = 0;
        while (LIMP_ACTIVE !== 1'b0 && n < 300) begin
            @(posedge MCLK);
            n++;
        end
        chk("limp left", 32'h0000_0000, {31'h0, LIMP_ACTIVE});
        // Lock loss with loss reset enabled gates the PLL path
        PLL_LOCK <= 1'b1;
        cyc(10);
        wb(1'b1, pllsel_pkg::PWR_RST_CTRL_OFS, 32'h0000_0001);
        PLL_LOCK <= 1'b0;
        cyc(10);
        chk("hard reset raised", 32'h0000_0001, {31'h0, HARD_RESET_REQ});
        rd(pllsel_pkg::CLK_STATUS_OFS, 32'h0000_0004, 32'h0000_0000);
        PLL_LOCK <= 1'b1;
        cyc(10);
        chk("hard reset dropped", 32'h0000_0000, {31'h0, HARD_RESET_REQ});
        // Backup bit follows the missing lock during hard reset
        wb(1'b1, pllsel_pkg::PWR_RST_CTRL_OFS, 32'h0000_0000);
        HARD_RESET_N <= 1'b0;
        PLL_LOCK <= 1'b0;
        cyc(10);
        rd(pllsel_pkg::SYS_CLK_CTRL_OFS, 32'h0000_0002, 32'h0000_0002);
        rd(pllsel_pkg::CLK_STATUS_OFS, 32'h0000_000D, 32'h0000_0008);
        PLL_LOCK <= 1'b1;
        cyc(10);
        rd(pllsel_pkg::SYS_CLK_CTRL_OFS, 32'h0000_0002, 32'h0000_0000);
        HARD_RESET_N <= 1'b1;
        cyc(10);
        wrap_up();
    end
endmodule : pll_lock_clock_selector_tb
